// File: hdl/fag_guard.sv
// Purpose: region decode and protection for in-application flash access
// Assumes: core sfr and data accesses are synchronous single-cycle strobes
// Notes: flash cell timing lives outside; this block gates and steers only
`include "fag_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module fag_guard #(
  parameter int FLASH_KB = 16 // 16 or 8
) (
  input wire logic i_ref_clk, // cpu clock
  input wire logic i_arst_n, // power-on reset, async, active low
  input wire fag_pkg::fag_sfr_type i_sfr, // sfr write strobe
  input wire logic [7:0] i_sfr_raddr, // sfr read address
  output logic [7:0] o_sfr_rdata, // sfr read data
  input wire fag_pkg::fag_xreq_type i_xreq, // data-space flash access
  output logic o_x_allowed, // data access permitted; a write also needs wr_en and no code read
  output logic o_x_blocked, // data access refused
  input wire logic i_code_req, // code read request
  input wire logic [13:0] i_code_addr, // code read address
  output logic o_code_allowed, // code read reaches flash
  output logic o_fetch_start, // high while the config load runs, before reset fetch may start at vector
  output logic [13:0] o_fl_addr, // flash array address
  output logic o_fl_rd, // flash array read strobe
  output logic o_fl_prog, // start one-byte program cycle
  output logic [7:0] o_fl_wdata, // byte to program
  input wire logic [7:0] i_fl_rdata, // flash array read data
  output logic [7:0] o_rd_data, // byte returned to the core
  output logic o_in_app_region, // access address lies in application region
  output logic o_ice_region, // data access address lies in emulation reserve
  output logic [7:0] o_cfg_low, // low config shadow to device control
  output logic [7:0] o_bg_trim, // bandgap trim shadow to device control
  output logic o_cfg_ready // config load finished
);

  // only the two documented array sizes have a region map
  if (FLASH_KB != 16 && FLASH_KB != 8) begin : g_bad_size
    $error("FLASH_KB must be 16 or 8");
  end

  // data-space protection decode, shared by read and write paths
  function automatic logic x_ok(input logic [13:0] a, input logic unl);
    if (a == `FAG_CFG_HIGH_ADDR) x_ok = 1'b0;
    else if (a > `FAG_OPEN_LAST) x_ok = unl;
    else if (a > `FAG_ALL_LAST) x_ok = 1'b1;
    else x_ok = unl;
  endfunction : x_ok

  // application region decode for the chosen size variant
  function automatic logic app_hit(input logic [13:0] a);
    if (FLASH_KB == 16) app_hit = a >= `FAG_APP16_FIRST && a <= `FAG_APP16_LAST;
    else app_hit = a >= `FAG_APP8_FIRST && a <= `FAG_APP8_LAST;
  endfunction : app_hit

  logic unlock; // full_area_unlock flag
  logic next_unlock;
  logic wr_en; // flash_write_enable flag
  logic next_wr_en;
  logic [7:0] cfg_low; // config_low_shadow
  logic [7:0] next_cfg_low;
  logic [7:0] bg_trim; // bandgap_trim_shadow
  logic [7:0] next_bg_trim;
  fag_pkg::fag_load_type load_st; // power-on load step
  fag_pkg::fag_load_type next_load_st;
  logic [7:0] rd_data; // registered return byte
  logic [7:0] next_rd_data;
  logic x_hit_ok; // current data access permitted
  logic x_wr_ok; // current data write permitted
  logic loading; // config load owns the flash port

  // command flags: key compare on every write to their sfr
  always_comb begin
    next_unlock = unlock;
    next_wr_en = wr_en;
    if (i_sfr.wr && i_sfr.addr == `FAG_SFR_SW_CMD) begin
      next_unlock = (i_sfr.wdata == `FAG_UNLOCK_KEY);
    end
    if (i_sfr.wr && i_sfr.addr == `FAG_SFR_WR_EN) begin
      next_wr_en = (i_sfr.wdata == `FAG_WREN_KEY);
    end
  end

  // flags drop on every reset, no software write survives it
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      unlock <= 1'b0;
      wr_en <= 1'b0;
    end else begin
      unlock <= next_unlock;
      wr_en <= next_wr_en;
    end
  end

  // power-on load walks two config addresses, then hands to software
  always_comb begin
    next_load_st = load_st;
    next_cfg_low = cfg_low;
    next_bg_trim = bg_trim;
    case (load_st)
      fag_pkg::LOAD_LOW: begin
        next_cfg_low = i_fl_rdata;
        next_load_st = fag_pkg::LOAD_TRIM;
      end
      fag_pkg::LOAD_TRIM: begin
        next_bg_trim = i_fl_rdata;
        next_load_st = fag_pkg::LOAD_DONE;
      end
      fag_pkg::LOAD_DONE: begin
        // software may overwrite both shadows afterwards
        if (i_sfr.wr && i_sfr.addr == `FAG_SFR_CFG_LOW) next_cfg_low = i_sfr.wdata;
        if (i_sfr.wr && i_sfr.addr == `FAG_SFR_BG_TRIM) next_bg_trim = i_sfr.wdata;
      end
      default: next_load_st = fag_pkg::LOAD_DONE;
    endcase
  end

  // shadows start at zero until the array has been read
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      load_st <= fag_pkg::LOAD_LOW;
      cfg_low <= 8'h00;
      bg_trim <= 8'h00;
    end else begin
      load_st <= next_load_st;
      cfg_low <= next_cfg_low;
      bg_trim <= next_bg_trim;
    end
  end

  assign loading = (load_st != fag_pkg::LOAD_DONE);
  assign x_hit_ok = i_xreq.req && !loading && x_ok(i_xreq.addr, unlock);
  // protected or disabled writes never reach the array
  assign x_wr_ok = x_hit_ok && i_xreq.wr && wr_en;

  // flash port steering: load first, then code reads, then data access
  always_comb begin
    o_fl_addr = i_xreq.addr;
    o_fl_rd = 1'b0;
    if (load_st == fag_pkg::LOAD_LOW) begin
      o_fl_addr = `FAG_CFG_LOW_ADDR;
      o_fl_rd = 1'b1;
    end else if (load_st == fag_pkg::LOAD_TRIM) begin
      o_fl_addr = `FAG_BG_TRIM_ADDR;
      o_fl_rd = 1'b1;
    end else if (i_code_req) begin
      o_fl_addr = i_code_addr;
      o_fl_rd = 1'b1;
    end else if (x_hit_ok && !i_xreq.wr) begin
      o_fl_rd = 1'b1;
    end
  end

  // once the config load is done a code read wins the port, so a data write is held back then
  assign o_fl_prog = x_wr_ok && !i_code_req;
  assign o_fl_wdata = i_xreq.wdata;
  assign o_code_allowed = i_code_req && !loading;
  assign o_x_allowed = x_hit_ok && !(i_xreq.wr && (!wr_en || i_code_req));
  assign o_x_blocked = i_xreq.req && !o_x_allowed;
  assign o_fetch_start = loading;
  assign o_in_app_region = app_hit(i_xreq.req ? i_xreq.addr : i_code_addr);
  // emulation reserve flagged only; keeping clear of it is up to software
  assign o_ice_region = i_xreq.req && i_xreq.addr >= `FAG_ICE_FIRST &&
                        i_xreq.addr <= `FAG_ICE_LAST;

  // return byte: a code read wins, else blocked data reads give zero
  always_comb begin
    next_rd_data = rd_data;
    if (!loading && i_code_req) next_rd_data = i_fl_rdata;
    else if (x_hit_ok && !i_xreq.wr) next_rd_data = i_fl_rdata;
    else if (i_xreq.req && !i_xreq.wr) next_rd_data = 8'h00;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) rd_data <= 8'h00;
    else rd_data <= next_rd_data;
  end

  // sfr read mux; command sfr shows only the unlock flag
  always_comb begin
    case (i_sfr_raddr)
      `FAG_SFR_SW_CMD: o_sfr_rdata = {7'h00, unlock};
      `FAG_SFR_WR_EN: o_sfr_rdata = {wr_en, 7'h00};
      `FAG_SFR_CFG_LOW: o_sfr_rdata = cfg_low;
      `FAG_SFR_BG_TRIM: o_sfr_rdata = bg_trim;
      default: o_sfr_rdata = 8'h00;
    endcase
  end

  assign o_rd_data = rd_data;
  assign o_cfg_low = cfg_low;
  assign o_bg_trim = bg_trim;
  assign o_cfg_ready = !loading;

  // named steps of the power-on load
  sequence s_low_load;
    load_st == fag_pkg::LOAD_LOW && o_fl_addr == `FAG_CFG_LOW_ADDR;
  endsequence
  sequence s_trim_load;
    load_st == fag_pkg::LOAD_TRIM && o_fl_addr == `FAG_BG_TRIM_ADDR;
  endsequence

  property p_load_seq;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      s_low_load |=> s_trim_load ##1 o_cfg_ready;
  endproperty
  a_load_seq: assert property (p_load_seq) else $error("config load order wrong");

  property p_low_copy;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      load_st == fag_pkg::LOAD_LOW |=> cfg_low == $past(i_fl_rdata);
  endproperty
  a_low_copy: assert property (p_low_copy) else $error("low config not copied");

  property p_high_never;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_xreq.req && i_xreq.addr == `FAG_CFG_HIGH_ADDR |-> !o_x_allowed && !o_fl_prog;
  endproperty
  a_high_never: assert property (p_high_never) else $error("high config reached");

  property p_locked_all;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_xreq.req && !unlock && i_xreq.addr <= `FAG_ALL_LAST |-> o_x_blocked;
  endproperty
  a_locked_all: assert property (p_locked_all) else $error("locked area reached");

  property p_free_open;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_xreq.req && !i_xreq.wr && o_cfg_ready && i_xreq.addr > `FAG_ALL_LAST &&
      i_xreq.addr <= `FAG_OPEN_LAST |-> o_x_allowed;
  endproperty
  a_free_open: assert property (p_free_open) else $error("free area refused");

  property p_guard_cfg;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_xreq.req && i_xreq.addr > `FAG_OPEN_LAST && i_xreq.addr <= `FAG_GUARD_LAST &&
      o_x_allowed |-> unlock;
  endproperty
  a_guard_cfg: assert property (p_guard_cfg) else $error("guarded config reached");

  property p_unlock_set;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_sfr.wr && i_sfr.addr == `FAG_SFR_SW_CMD |=>
      unlock == ($past(i_sfr.wdata) == `FAG_UNLOCK_KEY) &&
      (o_sfr_rdata[0] == unlock || i_sfr_raddr != `FAG_SFR_SW_CMD);
  endproperty
  a_unlock_set: assert property (p_unlock_set) else $error("unlock key wrong");

  property p_prog_needs;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      o_fl_prog |-> i_xreq.req && i_xreq.wr && wr_en && !i_code_req && o_cfg_ready &&
      x_ok(i_xreq.addr, unlock);
  endproperty
  a_prog_needs: assert property (p_prog_needs) else $error("unguarded program");

  property p_code_read;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_code_req && o_cfg_ready |-> o_fl_rd && o_fl_addr == i_code_addr
      ##1 o_rd_data == $past(i_fl_rdata);
  endproperty
  a_code_read: assert property (p_code_read) else $error("code read blocked");

endmodule : fag_guard
`default_nettype wire

// File: hdl/fag_pkg.sv
// Purpose: types for the flash access guard
// Assumes: fag_regs.svh holds the numbers
// Notes: no constants here beyond types
package fag_pkg;
  // power-on load sequence states
  typedef enum logic [1:0] {
    LOAD_LOW,
    LOAD_TRIM,
    LOAD_DONE
  } fag_load_type;
  // one data-space access from the core
  typedef struct packed {
    logic req;
    logic wr;
    logic [13:0] addr;
    logic [7:0] wdata;
  } fag_xreq_type;
  // one sfr write from the core
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fag_sfr_type;
endpackage : fag_pkg

// File: hdl/fag_regs.svh
// Purpose: constants for the flash access guard
// Assumes: byte addresses into a 16K flash space, sfr addresses 8 bits
// Notes: definitions only
`ifndef FAG_REGS_SVH
`define FAG_REGS_SVH
`define FAG_SFR_SW_CMD 8'h97
`define FAG_SFR_WR_EN 8'hc9
`define FAG_SFR_BG_TRIM 8'hf5
`define FAG_SFR_CFG_LOW 8'hf6
`define FAG_UNLOCK_KEY 8'h65
`define FAG_WREN_KEY 8'h47
`define FAG_VEC_LAST 14'h007f
`define FAG_APP16_FIRST 14'h3000
`define FAG_APP16_LAST 14'h3fef
`define FAG_APP8_FIRST 14'h1000
`define FAG_APP8_LAST 14'h1fef
`define FAG_ICE_FIRST 14'h2d00
`define FAG_ICE_LAST 14'h2fff
`define FAG_ALL_LAST 14'h3eff
`define FAG_FREE_LAST 14'h3fef
`define FAG_CONFIG_WORD_BLOCK_FIRST 14'h3ff0
`define FAG_OPEN_LAST 14'h3ff7
`define FAG_GUARD_LAST 14'h3ffe
`define FAG_CFG_HIGH_ADDR 14'h3fff
`define FAG_CFG_LOW_ADDR 14'h3ffd
`define FAG_BG_TRIM_ADDR 14'h3ffb
`define FAG_WREN_BIT 7
`define FAG_UNLOCK_BIT 0
`endif

// File: verification/fag_flash_model.sv
// Purpose: behavioural flash array on the far side of the guard
// Assumes: asynchronous read, one byte programmed per strobe
// Notes: preload is a pattern the bench recomputes on its own
`timescale 1ns/10ps
`default_nettype none
module fag_flash_model (
  input wire logic i_clk, // cpu clock
  input wire logic [13:0] i_addr, // array address
  input wire logic i_prog, // program strobe
  input wire logic [7:0] i_wdata, // byte to program
  output logic [7:0] o_rdata // array data
);
  logic [7:0] mem [0:16383]; // cell array
  // preload, config word at the top included
  initial begin
    for (int a = 0; a < 16384; a++) begin
      mem[a] = 8'(a) ^ 8'(a >> 8);
    end
  end
  // one byte per strobe, no erase step needed
  always @(posedge i_clk) begin
    if (i_prog === 1'b1) begin
      mem[i_addr] <= i_wdata;
    end
  end
  // unknown address gives a fixed 5a marker, never a stale byte
  assign o_rdata = ((^i_addr) === 1'bx) ? 8'h5a : mem[i_addr];
endmodule : fag_flash_model
`default_nettype wire

// File: verification/tb_flash_app_access_guard.sv
// Purpose: directed bench for the flash access guard
// Assumes: inputs change on the falling edge
// Notes: expected flash bytes come from the preload pattern
`timescale 1ns/10ps
`default_nettype none
module tb_flash_app_access_guard;
  logic i_ref_clk = 1'b0; // cpu clock
  logic i_arst_n = 1'b0; // reset
  fag_pkg::fag_sfr_type i_sfr = '0; // sfr write
  logic [7:0] i_sfr_raddr = 8'h00; // sfr read address
  fag_pkg::fag_xreq_type i_xreq = '0; // data access
  logic i_code_req = 1'b0; // code read
  logic [13:0] i_code_addr = 14'h0000; // code address
  logic [7:0] o_sfr_rdata, o_fl_wdata, fl_rdata, o_rd_data, o_cfg_low, o_bg_trim;
  logic [13:0] o_fl_addr; // flash address
  logic o_x_allowed, o_x_blocked, o_code_allowed, o_fetch_start, o_fl_rd, o_fl_prog;
  logic o_in_app_region, o_cfg_ready, o_ice_region; // region, load done, emulation reserve
  int error_cnt = 0; // mismatches
  int num_checks = 0; // comparisons
  // probe table: four sectors and their edges
  logic [13:0] ta [9] = '{14'h0000, 14'h3eff, 14'h3f00, 14'h3fef, 14'h3ff0, 14'h3ff7,
                          14'h3ff8, 14'h3ffe, 14'h3fff};
  logic [13:0] ra [4] = '{14'h2fff, 14'h3000, 14'h3fef, 14'h3ff0}; // region edges
  logic [3:0] rg = 4'b0110; // inside application region
  fag_guard #(.FLASH_KB(16)) dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_sfr(i_sfr), .i_sfr_raddr(i_sfr_raddr), .o_sfr_rdata(o_sfr_rdata),
    .i_xreq(i_xreq), .o_x_allowed(o_x_allowed), .o_x_blocked(o_x_blocked),
    .i_code_req(i_code_req), .i_code_addr(i_code_addr), .o_code_allowed(o_code_allowed),
    .o_fetch_start(o_fetch_start), .o_fl_addr(o_fl_addr), .o_fl_rd(o_fl_rd),
    .o_fl_prog(o_fl_prog), .o_fl_wdata(o_fl_wdata), .i_fl_rdata(fl_rdata),
    .o_rd_data(o_rd_data), .o_in_app_region(o_in_app_region), .o_ice_region(o_ice_region),
    .o_cfg_low(o_cfg_low), .o_bg_trim(o_bg_trim), .o_cfg_ready(o_cfg_ready));
  fag_flash_model flash (.i_clk(i_ref_clk), .i_addr(o_fl_addr), .i_prog(o_fl_prog),
    .i_wdata(o_fl_wdata), .o_rdata(fl_rdata));
  // clock
  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  function automatic logic [7:0] pat(input logic [13:0] a);
    return a[7:0] ^ {2'h0, a[13:8]};
  endfunction : pat
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one-cycle sfr write strobe
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge i_ref_clk);
    i_sfr.wr = 1'b0;
    // idle edge so a following write never re-raises the strobe in this step
    @(negedge i_ref_clk);
  endtask : sfr_wr
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    i_sfr_raddr = a;
    #1 chk("sfr_rdata", {8'h00, exp}, {8'h00, o_sfr_rdata});
    @(negedge i_ref_clk);
  endtask : sfr_rd
  // one data access; refused reads must return 00
  task automatic xacc(input logic wr, input logic [13:0] a, input logic [7:0] d,
                      input logic ok, input logic [7:0] rexp);
    i_xreq = '{req: 1'b1, wr: wr, addr: a, wdata: d};
    #1 chk("x_allowed", {15'h0, ok}, {15'h0, o_x_allowed});
    chk("x_blocked", {15'h0, !ok}, {15'h0, o_x_blocked});
    chk("fl_prog", {15'h0, ok & wr}, {15'h0, o_fl_prog});
    chk("fl_rd", {15'h0, ok & !wr}, {15'h0, o_fl_rd});
    chk("fl_addr", {2'h0, a}, {2'h0, o_fl_addr});
    chk("ice_region", {15'h0, a >= 14'h2d00 && a <= 14'h2fff}, {15'h0, o_ice_region});
    @(negedge i_ref_clk);
    i_xreq.req = 1'b0;
    if (!wr) chk("rd_data", {8'h00, rexp}, {8'h00, o_rd_data});
    // one idle cycle between accesses keeps req from toggling twice in a step
    @(negedge i_ref_clk);
  endtask : xacc
  task automatic crd(input logic [13:0] a);
    i_code_req = 1'b1;
    i_code_addr = a;
    #1 chk("code_allowed", 16'h0001, {15'h0, o_code_allowed});
    chk("code_fl_rd", 16'h0001, {15'h0, o_fl_rd});
    chk("code_fl_addr", {2'h0, a}, {2'h0, o_fl_addr});
    @(negedge i_ref_clk);
    i_code_req = 1'b0;
    chk("code_data", {8'h00, pat(a)}, {8'h00, o_rd_data});
    @(negedge i_ref_clk);
  endtask : crd
  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // hang guard, far beyond the roughly 130 cycles needed
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (20) @(negedge i_ref_clk);
    chk("fetch_start", 16'h0001, {15'h0, o_fetch_start});
    chk("fl_addr", 16'h3ffd, {2'h0, o_fl_addr});
    i_arst_n = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    chk("cfg_ready", 16'h0001, {15'h0, o_cfg_ready});
    chk("fetch_start", 16'h0000, {15'h0, o_fetch_start});
    chk("cfg_low", {8'h00, pat(14'h3ffd)}, {8'h00, o_cfg_low});
    chk("bg_trim", {8'h00, pat(14'h3ffb)}, {8'h00, o_bg_trim});
    sfr_rd(8'h97, 8'h00);
    for (int i = 0; i < 9; i++) begin
      xacc(1'b0, ta[i], 8'h00, i inside {[2:5]}, (i inside {[2:5]}) ? pat(ta[i]) : 8'h00);
    end
    sfr_wr(8'h97, 8'h65);
    sfr_rd(8'h97, 8'h01);
    for (int i = 0; i < 9; i++) begin
      xacc(1'b0, ta[i], 8'h00, i != 8, (i != 8) ? pat(ta[i]) : 8'h00);
    end
    sfr_wr(8'hc9, 8'h00);
    xacc(1'b1, 14'h3f10, 8'h5a, 1'b0, 8'h00);
    sfr_wr(8'hc9, 8'h47);
    sfr_rd(8'hc9, 8'h80);
    xacc(1'b1, 14'h3f10, 8'h5a, 1'b1, 8'h00);
    xacc(1'b0, 14'h3f10, 8'h00, 1'b1, 8'h5a);
    xacc(1'b1, 14'h3fff, 8'h11, 1'b0, 8'h00);
    xacc(1'b1, 14'h3000, 8'h77, 1'b1, 8'h00);
    xacc(1'b0, 14'h3000, 8'h00, 1'b1, 8'h77);
    sfr_wr(8'h97, 8'h64);
    sfr_rd(8'h97, 8'h00);
    xacc(1'b1, 14'h3001, 8'h33, 1'b0, 8'h00);
    xacc(1'b1, 14'h3ffd, 8'h33, 1'b0, 8'h00);
    xacc(1'b0, 14'h2cff, 8'h00, 1'b0, 8'h00);
    xacc(1'b0, 14'h2d00, 8'h00, 1'b0, 8'h00);
    xacc(1'b0, 14'h2fff, 8'h00, 1'b0, 8'h00);
    crd(14'h3001);
    for (int i = 0; i < 9; i++) begin
      crd(ta[i]);
    end
    sfr_wr(8'hf6, 8'ha5);
    sfr_rd(8'hf6, 8'ha5);
    sfr_wr(8'hf5, 8'h3c);
    sfr_rd(8'hf5, 8'h3c);
    for (int i = 0; i < 4; i++) begin
      i_code_addr = ra[i];
      #1 chk("app_region", {15'h0, rg[i]}, {15'h0, o_in_app_region});
      @(negedge i_ref_clk);
    end
    @(negedge i_ref_clk);
    sfr_wr(8'h97, 8'h65);
    i_arst_n = 1'b0;
    @(negedge i_ref_clk);
    i_arst_n = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    sfr_rd(8'h97, 8'h00);
    xacc(1'b0, 14'h3ff8, 8'h00, 1'b0, 8'h00);
    chk("cfg_low_reload", {8'h00, pat(14'h3ffd)}, {8'h00, o_cfg_low});
    chk("bg_trim_reload", {8'h00, pat(14'h3ffb)}, {8'h00, o_bg_trim});
    sfr_rd(8'hc9, 8'h00);
    final_report();
  end
endmodule : tb_flash_app_access_guard
`default_nettype wire
